// [hw/nbm_host_regs.vh]
// Constants for the NAND block-management host controller
`ifndef NBM_HOST_REGS_VH
`define NBM_HOST_REGS_VH

`define NBM_CLK_MHZ 200
// Bus cycle half period in clocks (40 ns)
`define NBM_HALF 8
// Least times round up, longest times round down
`define NBM_T_POR_NS 20000
`define NBM_POR_CYC ((`NBM_T_POR_NS * `NBM_CLK_MHZ + 999) / 1000)
`define NBM_T_SLEEP_NS 10000
`define NBM_SLEEP_CYC ((`NBM_T_SLEEP_NS * `NBM_CLK_MHZ) / 1000)
`define NBM_T_TCS_NS 2000
`define NBM_TCS_CYC ((`NBM_T_TCS_NS * `NBM_CLK_MHZ + 999) / 1000)
`define NBM_T_WB_NS 100
`define NBM_WB_CYC ((`NBM_T_WB_NS * `NBM_CLK_MHZ + 999) / 1000)
`define NBM_T_WHR_NS 60
`define NBM_WHR_CYC ((`NBM_T_WHR_NS * `NBM_CLK_MHZ + 999) / 1000)

// Flash commands
`define NBM_CMD_READ1 8'h00
`define NBM_CMD_READ2 8'h30
`define NBM_CMD_PROG1 8'h80
`define NBM_CMD_PROG2 8'h10
`define NBM_CMD_ERASE1 8'h60
`define NBM_CMD_ERASE2 8'hD0
`define NBM_CMD_STATUS 8'h70
`define NBM_ERASED 8'hFF

// Status byte fields
`define NBM_SR_FAIL 0
`define NBM_SR_READY 6

// User operations and results
`define NBM_OP_READ 2'h0
`define NBM_OP_PROG 2'h1
`define NBM_OP_ERASE 2'h2
`define NBM_OP_SCAN 2'h3
`define NBM_RES_OK 2'h0
`define NBM_RES_FAIL 2'h1
`define NBM_RES_BAD 2'h2
`define NBM_RES_ORDER 2'h3

`endif

// [hw/nbm_host.v]
// Host controller for a NAND flash: bring-up, bad-block table, page order
`timescale 1ns/1ps
`include "nbm_host_regs.vh"

module nbm_host #(
	parameter BLK_W = 10,
	parameter PAGE_BYTES = 2048
) (
	input wire i_clock,
	input wire i_reset,
	input wire i_power_down,
	input wire i_cmd_valid,
	input wire [1:0] i_cmd_op,
	input wire [BLK_W-1:0] i_cmd_block,
	input wire [5:0] i_cmd_page,
	output wire o_cmd_ready,
	input wire [7:0] i_wr_data,
	input wire i_wr_valid,
	output wire o_wr_ready,
	output reg [7:0] o_rd_data,
	output reg o_rd_valid,
	output reg o_done,
	output reg [1:0] o_result,
	output reg o_ready,
	output reg o_nand_ce_n,
	output reg o_nand_cle,
	output reg o_nand_ale,
	output reg o_nand_we_n,
	output reg o_nand_re_n,
	output reg o_nand_wp_n,
	output reg [7:0] o_nand_io,
	output reg o_nand_io_oe,
	input wire [7:0] i_nand_io,
	input wire i_nand_rb_n
);

	localparam [3:0] S_POR = 4'h0;
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_WAKE = 4'h2;
	localparam [3:0] S_CMD1 = 4'h3;
	localparam [3:0] S_ADDR = 4'h4;
	localparam [3:0] S_WDATA = 4'h5;
	localparam [3:0] S_CMD2 = 4'h6;
	localparam [3:0] S_BUSY = 4'h7;
	localparam [3:0] S_STCMD = 4'h8;
	localparam [3:0] S_STAT = 4'h9;
	localparam [3:0] S_RDATA = 4'hA;

	localparam [4:0] HALF = `NBM_HALF;
	localparam [4:0] CYC_END = 2 * `NBM_HALF;
	localparam [4:0] SAMPLE = `NBM_HALF + 1;
	localparam [15:0] POR_CYC = `NBM_POR_CYC;
	localparam [15:0] SLEEP_CYC = `NBM_SLEEP_CYC;
	localparam [15:0] TCS_CYC = `NBM_TCS_CYC;
	localparam [15:0] WB_CYC = `NBM_WB_CYC;
	localparam [15:0] WHR_CYC = `NBM_WHR_CYC;
	localparam [12:0] LAST_BYTE = PAGE_BYTES - 1;
	localparam [15:0] SPARE_COL = PAGE_BYTES;
	localparam [BLK_W-1:0] LAST_BLK = {BLK_W{1'b1}};
	localparam NBLK = 1 << BLK_W;

	reg bad_q [0:NBLK-1];
	reg [6:0] next_q [0:NBLK-1];

	reg [3:0] st_q, st_d;
	reg [4:0] tick_q, tick_d;
	reg [15:0] wt_q, wt_d;
	reg [15:0] idle_q, idle_d;
	reg [1:0] op_q, op_d;
	reg [BLK_W-1:0] blk_q, blk_d;
	reg [5:0] pg_q, pg_d;
	reg [2:0] acnt_q, acnt_d;
	reg [12:0] cnt_q, cnt_d;
	reg [7:0] wdat_q, wdat_d;
	reg [7:0] stat_q, stat_d;
	reg por_wait_q, por_wait_d;
	reg up_q, up_d;
	reg scan_done_d;
	reg [7:0] rd_data_d;
	reg rd_valid_d, done_d;
	reg [1:0] result_d;
	reg bad_we, bad_wd, next_we;
	reg [6:0] next_wd;
	reg [7:0] cmd_byte, io_d;
	reg ce_n_d, cle_d, ale_d, we_n_d, re_n_d, oe_d;

	wire [23:0] row = {{(18 - BLK_W){1'b0}}, blk_q, pg_q};
	wire [15:0] col = (op_q == `NBM_OP_SCAN) ? SPARE_COL : 16'h0000;
	wire [39:0] addr = {row, col};
	wire cyc_end = (tick_q == CYC_END);
	wire strobe = (wt_q == 16'h0000) && (tick_q != 5'h00) && (tick_q <= HALF);
	// Select rises a clock after idle starts, so count one less
	wire asleep = (idle_q >= SLEEP_CYC - 16'h0001);
	wire is_wr = (st_q == S_CMD1) || (st_q == S_ADDR) || (st_q == S_WDATA)
		|| (st_q == S_CMD2) || (st_q == S_STCMD);
	wire is_rd = (st_q == S_STAT) || (st_q == S_RDATA);

	assign o_cmd_ready = (st_q == S_IDLE);
	assign o_wr_ready = (st_q == S_WDATA) && (wt_q == 16'h0000)
		&& (tick_q == 5'h00);

	always @* begin
		case (st_q)
		S_CMD1: cmd_byte = (op_q == `NBM_OP_PROG) ? `NBM_CMD_PROG1 :
			(op_q == `NBM_OP_ERASE) ? `NBM_CMD_ERASE1 : `NBM_CMD_READ1;
		S_CMD2: cmd_byte = (op_q == `NBM_OP_PROG) ? `NBM_CMD_PROG2 :
			(op_q == `NBM_OP_ERASE) ? `NBM_CMD_ERASE2 : `NBM_CMD_READ2;
		S_ADDR: cmd_byte = addr[8*acnt_q +: 8];
		S_WDATA: cmd_byte = wdat_q;
		default: cmd_byte = `NBM_CMD_STATUS;
		endcase
		io_d = is_wr ? cmd_byte : 8'h00;
		oe_d = is_wr;
		ce_n_d = (st_q == S_POR) || (st_q == S_IDLE);
		cle_d = (st_q == S_CMD1) || (st_q == S_CMD2) || (st_q == S_STCMD);
		ale_d = (st_q == S_ADDR);
		we_n_d = !(is_wr && strobe);
		re_n_d = !(is_rd && strobe);
	end

	always @* begin
		st_d = st_q;
		tick_d = tick_q;
		wt_d = wt_q;
		idle_d = 16'h0000;
		op_d = op_q;
		blk_d = blk_q;
		pg_d = pg_q;
		acnt_d = acnt_q;
		cnt_d = cnt_q;
		wdat_d = wdat_q;
		stat_d = stat_q;
		por_wait_d = por_wait_q;
		up_d = up_q;
		scan_done_d = o_ready;
		rd_data_d = o_rd_data;
		rd_valid_d = 1'b0;
		done_d = 1'b0;
		result_d = o_result;
		bad_we = 1'b0;
		bad_wd = 1'b0;
		next_we = 1'b0;
		next_wd = 7'h00;
		if (wt_q != 16'h0000) begin
			wt_d = wt_q - 16'h0001;
		end else begin
			if (is_wr || is_rd) begin
				tick_d = cyc_end ? 5'h00 : tick_q + 5'h01;
			end
			case (st_q)
			S_POR: begin
				// Initialisation shows as busy; wait the typical time first
				if (!por_wait_q) begin
					wt_d = POR_CYC;
					por_wait_d = 1'b1;
				end else if (i_nand_rb_n) begin
					up_d = 1'b1;
					op_d = `NBM_OP_SCAN;
					blk_d = {BLK_W{1'b0}};
					pg_d = 6'h00;
					st_d = S_WAKE;
				end
			end
			S_IDLE: begin
				idle_d = asleep ? idle_q : idle_q + 16'h0001;
				if (i_cmd_valid) begin
					op_d = i_cmd_op;
					blk_d = i_cmd_block;
					pg_d = i_cmd_page;
					if (i_cmd_op == `NBM_OP_SCAN) begin
						done_d = 1'b1;
						result_d = `NBM_RES_BAD;
					end else if (bad_q[i_cmd_block]) begin
						done_d = 1'b1;
						result_d = `NBM_RES_BAD;
					end else if (i_cmd_op == `NBM_OP_PROG &&
						{1'b0, i_cmd_page} < next_q[i_cmd_block]) begin
						done_d = 1'b1;
						result_d = `NBM_RES_ORDER;
					end else begin
						st_d = asleep ? S_WAKE : S_CMD1;
						idle_d = idle_q;
					end
				end
			end
			S_WAKE: begin
				wt_d = TCS_CYC;
				st_d = S_CMD1;
			end
			S_CMD1: if (cyc_end) begin
				acnt_d = (op_q == `NBM_OP_ERASE) ? 3'h2 : 3'h0;
				st_d = S_ADDR;
			end
			S_ADDR: if (cyc_end) begin
				acnt_d = acnt_q + 3'h1;
				cnt_d = 13'h0000;
				if (acnt_q == 3'h4) begin
					st_d = (op_q == `NBM_OP_PROG) ? S_WDATA : S_CMD2;
				end
			end
			S_WDATA: begin
				if (tick_q == 5'h00) begin
					if (i_wr_valid) begin
						wdat_d = i_wr_data;
					end else begin
						tick_d = 5'h00;
					end
				end
				if (cyc_end) begin
					cnt_d = cnt_q + 13'h0001;
					if (cnt_q == LAST_BYTE) begin
						st_d = S_CMD2;
					end
				end
			end
			S_CMD2: if (cyc_end) begin
				wt_d = WB_CYC;
				st_d = S_BUSY;
			end
			S_BUSY: if (i_nand_rb_n) begin
				cnt_d = 13'h0000;
				st_d = (op_q == `NBM_OP_PROG || op_q == `NBM_OP_ERASE) ?
					S_STCMD : S_RDATA;
			end
			S_STCMD: if (cyc_end) begin
				wt_d = WHR_CYC;
				st_d = S_STAT;
			end
			S_STAT: begin
				if (tick_q == SAMPLE) begin
					stat_d = i_nand_io;
				end
				// Poll again while the ready bit still reads busy
				if (cyc_end && stat_q[`NBM_SR_READY]) begin
					done_d = 1'b1;
					st_d = S_IDLE;
					if (stat_q[`NBM_SR_FAIL]) begin
						// Later requests to this block, reads included, are refused as bad
						bad_we = 1'b1;
						bad_wd = 1'b1;
						result_d = `NBM_RES_FAIL;
					end else begin
						result_d = `NBM_RES_OK;
						next_we = 1'b1;
						next_wd = (op_q == `NBM_OP_PROG) ?
							{1'b0, pg_q} + 7'h01 : 7'h00;
					end
				end
			end
			S_RDATA: begin
				if (tick_q == SAMPLE) begin
					rd_data_d = i_nand_io;
					rd_valid_d = (op_q == `NBM_OP_READ);
					if (op_q == `NBM_OP_SCAN) begin
						// Page 0 clears stale table entries; page 1 only sets
						bad_we = (pg_q == 6'h00) ||
							(i_nand_io != `NBM_ERASED);
						bad_wd = (i_nand_io != `NBM_ERASED);
						next_we = (pg_q == 6'h00);
					end
				end
				if (cyc_end) begin
					cnt_d = cnt_q + 13'h0001;
					if (op_q == `NBM_OP_READ) begin
						if (cnt_q == LAST_BYTE) begin
							done_d = 1'b1;
							result_d = `NBM_RES_OK;
							st_d = S_IDLE;
						end
					end else if (pg_q == 6'h00) begin
						pg_d = 6'h01;
						st_d = S_CMD1;
					end else if (blk_q == LAST_BLK) begin
						scan_done_d = 1'b1;
						st_d = S_IDLE;
					end else begin
						blk_d = blk_q + {{(BLK_W - 1){1'b0}}, 1'b1};
						pg_d = 6'h00;
						st_d = S_CMD1;
					end
				end
			end
			default: st_d = S_IDLE;
			endcase
		end
	end

	always @(posedge i_clock) begin
		if (bad_we) begin
			bad_q[blk_q] <= bad_wd;
		end
		if (next_we) begin
			next_q[blk_q] <= next_wd;
		end
	end

	always @(posedge i_clock) begin
		if (i_reset) begin
			st_q <= S_POR;
			tick_q <= 5'h00;
			wt_q <= 16'h0000;
			idle_q <= 16'h0000;
			op_q <= `NBM_OP_SCAN;
			blk_q <= {BLK_W{1'b0}};
			pg_q <= 6'h00;
			acnt_q <= 3'h0;
			cnt_q <= 13'h0000;
			wdat_q <= 8'h00;
			stat_q <= 8'h00;
			por_wait_q <= 1'b0;
			up_q <= 1'b0;
			o_ready <= 1'b0;
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
			o_done <= 1'b0;
			o_result <= `NBM_RES_OK;
			o_nand_ce_n <= 1'b1;
			o_nand_cle <= 1'b0;
			o_nand_ale <= 1'b0;
			o_nand_we_n <= 1'b1;
			o_nand_re_n <= 1'b1;
			o_nand_wp_n <= 1'b0;
			o_nand_io <= 8'h00;
			o_nand_io_oe <= 1'b0;
		end else begin
			st_q <= st_d;
			tick_q <= tick_d;
			wt_q <= wt_d;
			idle_q <= idle_d;
			op_q <= op_d;
			blk_q <= blk_d;
			pg_q <= pg_d;
			acnt_q <= acnt_d;
			cnt_q <= cnt_d;
			wdat_q <= wdat_d;
			stat_q <= stat_d;
			por_wait_q <= por_wait_d;
			up_q <= up_d;
			o_ready <= scan_done_d;
			o_rd_data <= rd_data_d;
			o_rd_valid <= rd_valid_d;
			o_done <= done_d;
			o_result <= result_d;
			o_nand_ce_n <= ce_n_d;
			o_nand_cle <= cle_d;
			o_nand_ale <= ale_d;
			o_nand_we_n <= we_n_d;
			o_nand_re_n <= re_n_d;
			o_nand_wp_n <= up_d && !i_power_down;
			o_nand_io <= io_d;
			o_nand_io_oe <= oe_d;
		end
	end

endmodule

// [testbench/nbm_host_chk_sva.sv]
// Port assertions for the NAND host controller
`timescale 1ns/1ps
module nbm_host_chk (
	input wire i_clock,
	input wire i_reset,
	input wire i_power_down,
	input wire i_cmd_valid,
	input wire [1:0] i_cmd_op,
	input wire o_cmd_ready,
	input wire o_done,
	input wire [1:0] o_result,
	input wire o_ready,
	input wire o_nand_ce_n,
	input wire o_nand_we_n,
	input wire o_nand_re_n,
	input wire o_nand_wp_n,
	input wire i_nand_rb_n
);
	// Counters hold spans too long to unroll
	logic [12:0] pc_q = '0;
	logic [12:0] hc_q = '0;
	logic [8:0] wc_q = '0;
	logic wk_q = 1'b0;
	wire wake = !o_nand_ce_n && hc_q >= 13'h07D0;
	wire take = i_cmd_valid && o_cmd_ready;
	always @(posedge i_clock) begin
		pc_q <= i_reset ? '0 : pc_q + {12'h000, pc_q != 13'h1FFF};
		hc_q <= o_nand_ce_n ? hc_q + {12'h000, hc_q != 13'h1FFF} : '0;
		wc_q <= wake ? '0 : wc_q + 1'b1;
		wk_q <= !i_reset && (wake || (wk_q && wc_q != 9'h018D));
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	reset_pins_a: assert property (disable iff (1'b0)
		i_reset |=> o_nand_ce_n && !o_nand_wp_n) else $error("Reset pins");
	pwr_wp_a: assert property (i_power_down |=> !o_nand_wp_n)
		else $error("Protect late");
	por_wait_a: assert property (pc_q < 13'h0FA0 |-> o_nand_ce_n)
		else $error("Select too early");
	scan_first_a: assert property (o_cmd_ready |-> o_ready)
		else $error("Request before scan");
	table_kept_a: assert property (o_ready |=> o_ready)
		else $error("Ready dropped");
	wake_wait_a: assert property (
		wake || wk_q |-> o_nand_we_n && o_nand_re_n) else $error("Wake");
	refuse_op_a: assert property (
		take && i_cmd_op == 2'h3 |=> o_done && o_result == 2'h2)
		else $error("Op not refused");
	busy_quiet_a: assert property (
		!i_nand_rb_n && !o_nand_ce_n |-> o_nand_we_n) else $error("Busy");
	cover property (o_done && o_result == 2'h1);
	cover property (o_done && o_result == 2'h3);
	cover property (wake);
endmodule
bind nbm_host nbm_host_chk u_chk (.i_clock(i_clock), .i_reset(i_reset),
	.i_power_down(i_power_down), .i_cmd_valid(i_cmd_valid),
	.i_cmd_op(i_cmd_op), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
	.o_result(o_result), .o_ready(o_ready), .o_nand_ce_n(o_nand_ce_n),
	.o_nand_we_n(o_nand_we_n), .o_nand_re_n(o_nand_re_n),
	.o_nand_wp_n(o_nand_wp_n), .i_nand_rb_n(i_nand_rb_n));

// [testbench/nbm_dev_model.sv]
// Behavioural NAND flash device facing the host controller
`timescale 1ns/1ps
module nbm_dev_model #(
	parameter PB = 4,
	parameter BAD = 3,
	parameter FBL = 5
) (
	input wire i_clock,
	input wire i_reset,
	input wire i_ce_n,
	input wire i_cle,
	input wire i_ale,
	input wire i_we_n,
	input wire i_re_n,
	input wire [7:0] i_io,
	output wire [7:0] o_io,
	output wire o_rb_n,
	output logic o_err
);
	logic [7:0] mem [logic [39:0]];
	logic [7:0] a [5];
	logic [7:0] dq;
	logic [15:0] col;
	logic [2:0] ac;
	logic st, fl, we_q, re_q, slp;
	int busy = 4000;
	int hc = 0;
	int wc = 0;
	wire [39:0] k = {a[4], a[3], a[2], col};
	// Released bus shows the inverse of the last byte
	assign o_io = i_re_n ? ~dq : dq;
	assign o_rb_n = busy == 0;
	initial mem[{24'(BAD * 64), 16'(PB)}] = 8'h00;
	always @(posedge i_clock) begin
		we_q <= i_we_n;
		re_q <= i_re_n;
		busy <= busy > 0 ? busy - 1 : 0;
		hc <= i_ce_n ? hc + 1 : 0;
		wc <= wc + 1;
		// Only a select still high may fall asleep
		if (i_ce_n && hc >= 2000) slp <= 1;
		if (!i_ce_n && slp) begin
			slp <= 0;
			wc <= 0;
		end
		// Slack of two clocks for pin registering
		if (!i_ce_n && !i_we_n && we_q && wc < 398) o_err <= 1;
		if (i_reset) begin
			busy <= 4000;
			a <= '{default: 8'h00};
			col <= '0;
			o_err <= 0;
		end else if (!i_ce_n && i_we_n && !we_q) begin
			if (i_cle) begin
				st <= i_io == 8'h70;
				ac <= i_io == 8'h60 ? 3'h2 : 3'h0;
				if (i_io inside {8'h30, 8'h10, 8'hD0}) busy <= 50;
				fl <= k[39:22] == FBL;
			end else if (i_ale) begin
				a[ac] <= i_io;
				ac <= ac + 3'h1;
				if (ac == 3'h1) col <= {i_io, a[0]};
			end else begin
				mem[k] = i_io;
				col <= col + 16'h0001;
			end
		end else if (!i_ce_n && !i_re_n && re_q) begin
			dq <= st ? {1'b1, {2{busy == 0}}, 4'h0, fl}
				: mem.exists(k) ? mem[k] : 8'hFF;
			col <= col + 16'h0001;
		end
	end
endmodule

// [testbench/nbm_host_test.sv]
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
module nbm_host_test;
	logic clk = 0, rst = 1, pd = 0, cv = 0, wv = 0;
	logic [1:0] op = 2'h0;
	logic [2:0] blk = 3'h0;
	logic [5:0] pg = 6'h00;
	logic [7:0] wd = 8'h00;
	wire cr, wr, rv, dn, rdy, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb, err;
	wire [1:0] res;
	wire [7:0] rd, io_o, dv;
	wire [7:0] bus = oe ? io_o : dv;
	int fail_count = 0;
	int n_tests = 0;
	nbm_host #(.BLK_W(3), .PAGE_BYTES(4)) uut (.i_clock(clk),
		.i_reset(rst), .i_power_down(pd), .i_cmd_valid(cv),
		.i_cmd_op(op), .i_cmd_block(blk), .i_cmd_page(pg),
		.o_cmd_ready(cr), .i_wr_data(wd), .i_wr_valid(wv),
		.o_wr_ready(wr), .o_rd_data(rd), .o_rd_valid(rv), .o_done(dn),
		.o_result(res), .o_ready(rdy), .o_nand_ce_n(ce_n),
		.o_nand_cle(cle), .o_nand_ale(ale), .o_nand_we_n(we_n),
		.o_nand_re_n(re_n), .o_nand_wp_n(wp_n), .o_nand_io(io_o),
		.o_nand_io_oe(oe), .i_nand_io(bus), .i_nand_rb_n(rb));
	nbm_dev_model dev (.i_clock(clk), .i_reset(rst), .i_ce_n(ce_n),
		.i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
		.i_io(bus), .o_io(dv), .o_rb_n(rb), .o_err(err));
	initial forever #2.5 clk = ~clk;
	task automatic check(input [7:0] got, input [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Erased pages expect FFh, others base plus byte index
	task automatic run(input [1:0] o, input [2:0] b, input [5:0] p,
		input [7:0] base, input [1:0] exp);
		int n, m, k;
		logic took;
		n = 0;
		m = 0;
		k = 0;
		took = 0;
		// Let an edge pass so the last strobe is not driven twice
		@(negedge clk);
		{op, blk, pg, wd, wv, cv} = {o, b, p, base, o == 2'h1, 1'b1};
		while (cr !== 1'b1) @(negedge clk);
		do begin
			@(negedge clk);
			cv = 0;
			if (took) n++;
			wd = 8'(base + n);
			took = wr === 1'b1 && wv && n < 4;
			wv = wv && n < 4;
			if (rv === 1'b1) check(rd, 8'(base + (base == 8'hFF ? 0 : m)));
			if (rv === 1'b1) m++;
			k++;
		end while (dn !== 1'b1 && k < 9000);
		// A request that never ends counts as a mismatch
		check({7'h00, dn}, 8'h01);
		check({6'h00, res}, {6'h00, exp});
		if (o == 2'h0 && exp == 2'h0) check(8'(m), 8'h04);
	endtask
	task automatic t_init;
		check({6'h00, ce_n, wp_n}, 8'h02);
		rst = 0;
		for (int k = 0; k < 20000 && rdy !== 1'b1; k++) @(negedge clk);
		check({7'h00, rdy}, 8'h01);
		run(2'h0, 3'h3, 6'h00, 8'h00, 2'h2);
		run(2'h2, 3'h3, 6'h00, 8'h00, 2'h2);
		run(2'h3, 3'h0, 6'h00, 8'h00, 2'h2);
	endtask
	task automatic t_order;
		run(2'h1, 3'h1, 6'h00, 8'h10, 2'h0);
		run(2'h0, 3'h1, 6'h00, 8'h10, 2'h0);
		run(2'h1, 3'h1, 6'h00, 8'h10, 2'h3);
		run(2'h1, 3'h1, 6'h02, 8'h20, 2'h0);
		run(2'h1, 3'h1, 6'h01, 8'h30, 2'h3);
	endtask
	task automatic t_sleep;
		repeat (2500) @(negedge clk);
		run(2'h0, 3'h1, 6'h02, 8'h20, 2'h0);
		check({7'h00, err}, 8'h00);
	endtask
	task automatic t_fail;
		run(2'h1, 3'h5, 6'h00, 8'h40, 2'h1);
		run(2'h0, 3'h5, 6'h00, 8'h40, 2'h2);
	endtask
	task automatic t_erase;
		run(2'h2, 3'h1, 6'h00, 8'h00, 2'h0);
		run(2'h1, 3'h1, 6'h00, 8'h50, 2'h0);
		run(2'h0, 3'h2, 6'h00, 8'hFF, 2'h0);
	endtask
	task automatic t_power;
		pd = 1;
		repeat (2) @(negedge clk);
		check({7'h00, wp_n}, 8'h00);
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		t_init;
		t_order;
		t_sleep;
		t_fail;
		t_erase;
		t_power;
		give_verdict;
	end
	// Run needs about 12k clocks; over three times that is a hang
	initial begin
		#200000;
		fail_count++;
		give_verdict;
	end
endmodule
